//--- src/nested_irq_pkg.sv
// Constants, source indices and types shared by the nested interrupt controller
package nested_irq_pkg;

  // ==========================================================================
  // Sizes
  localparam int NUM_CHAN = 32;
  localparam int PRIO_W   = 2;
  localparam int NUM_SYS  = 5;
  localparam int NUM_SRC  = NUM_SYS + NUM_CHAN;
  localparam int IDX_W    = 6;
  localparam int RANK_W   = 3;
  localparam int EXT_W    = 32;

  // ==========================================================================
  // Source index: fixed and system exceptions first, in default order
  localparam int SRC_NMI   = 0;
  localparam int SRC_HARD  = 1;
  localparam int SRC_SVC   = 2;
  localparam int SRC_PSV   = 3;
  localparam int SRC_TICK  = 4;
  localparam int SRC_CHAN0 = 5;

  // Urgency ranks, lower wins; settable levels sit above the fixed ones
  localparam logic [RANK_W-1:0] RANK_NMI      = 3'h0;
  localparam logic [RANK_W-1:0] RANK_HARD     = 3'h1;
  localparam logic [RANK_W-1:0] RANK_SET_BASE = 3'h2;
  localparam logic [RANK_W-1:0] RANK_LOWEST   = 3'h5;

  // ==========================================================================
  // Vector byte addresses
  localparam logic [31:0] VEC_NMI       = 32'h0000_0008;
  localparam logic [31:0] VEC_HARD      = 32'h0000_000C;
  localparam logic [31:0] VEC_SVC       = 32'h0000_002C;
  localparam logic [31:0] VEC_PSV       = 32'h0000_0038;
  localparam logic [31:0] VEC_TICK      = 32'h0000_003C;
  localparam logic [31:0] VEC_CHAN_BASE = 32'h0000_0040;
  localparam int          VEC_SHIFT     = 2;

  // ==========================================================================
  // Channel positions and merged event lines
  localparam int CH_RTC      = 2;
  localparam int CH_EXT_LOW  = 5;
  localparam int CH_EXT_MID  = 6;
  localparam int CH_EXT_UP   = 7;
  localparam int CH_XFER_A   = 10;
  localparam int CH_XFER_B   = 11;
  localparam int CH_ADV_MISC = 13;
  localparam int CH_ADV_CC   = 14;
  localparam int CH_SER_UP   = 29;
  localparam int CH_USB      = 31;

  localparam int EXT_RTC_ALARM = 17;
  localparam int EXT_USB_WAKE  = 18;
  localparam int EXT_RTC_TAMP  = 19;
  localparam int EXT_RTC_WAKE  = 20;
  localparam int EXT_SER_WAKE  = 28;
  localparam int EXT_LOW_LO    = 0;
  localparam int EXT_LOW_HI    = 1;
  localparam int EXT_MID_LO    = 2;
  localparam int EXT_MID_HI    = 3;
  localparam int EXT_UP_LO     = 4;
  localparam int EXT_UP_HI     = 15;

  // Channels built here from dedicated inputs, and positions never used
  localparam logic [NUM_CHAN-1:0] MERGED_MASK   = 32'hA000_6CE4;
  localparam logic [NUM_CHAN-1:0] RESERVED_MASK = 32'h4000_8102;

  // ==========================================================================
  // Tick calibration: reference period over the tick clock
  localparam int          TICK_HZ       = 6_000_000;
  localparam int          REF_PERIOD_US = 1000;
  localparam int          CALIB_W       = 24;
  localparam logic [CALIB_W-1:0] TICK_CALIB = CALIB_W'(TICK_HZ / 1_000_000 * REF_PERIOD_US);

  typedef enum logic [0:0] {
    ST_IDLE  = 1'b0,
    ST_ENTRY = 1'b1
  } entry_state_t;

endpackage

//--- src/prio_select.sv
// Picks the most urgent pending source; ties go to the lowest index
`timescale 1ns/1ps
module prio_select #(
  parameter int N  = 37,
  parameter int IW = 6,
  parameter int RW = 3
) (
  input  wire logic [N-1:0]    pend,
  input  wire logic [N*RW-1:0] rank,
  output logic                 valid,
  output logic [IW-1:0]        idx,
  output logic [RW-1:0]        rank_out
);

  // ==========================================================================
  // Linear scan; strict compare keeps the earlier index on equal rank
  always_comb
  begin
    valid    = 1'b0;
    idx      = '0;
    rank_out = '1;
    for (int i = 0; i < N; i++)
    begin
      if (pend[i] && (!valid || rank[i*RW +: RW] < rank_out))
      begin
        valid    = 1'b1;
        idx      = IW'(i);
        rank_out = rank[i*RW +: RW];
      end
    end
  end

endmodule

//--- src/nested_irq_ctrl.sv
// Nested interrupt controller: channel merging, pending, arbitration, vector entry
`timescale 1ns/1ps
module nested_irq_ctrl (
  input  wire logic                                       clk_sys,
  input  wire logic                                       nrst,
  input  wire logic [nested_irq_pkg::NUM_CHAN-1:0]        periph_irq,
  input  wire logic [nested_irq_pkg::EXT_W-1:0]           ext_event_lines,
  input  wire logic [3:0]                                 xfer_ch_irq,
  input  wire logic [3:0]                                 adv_timer_misc_src,
  input  wire logic                                       adv_timer_capcmp_irq,
  input  wire logic [3:0]                                 serial_ports_upper_src,
  input  wire logic                                       usb_irq,
  input  wire logic                                       clock_failure_detector,
  input  wire logic                                       hard_fault_req,
  input  wire logic                                       supervisor_call_req,
  input  wire logic                                       pendable_service_req,
  input  wire logic                                       system_tick_req,
  input  wire logic [nested_irq_pkg::NUM_CHAN-1:0]        chan_enable,
  input  wire logic [nested_irq_pkg::NUM_CHAN*nested_irq_pkg::PRIO_W-1:0] chan_prio,
  input  wire logic [nested_irq_pkg::PRIO_W-1:0]          supervisor_call_prio,
  input  wire logic [nested_irq_pkg::PRIO_W-1:0]          pendable_service_prio,
  input  wire logic [nested_irq_pkg::PRIO_W-1:0]          system_tick_prio,
  input  wire logic                                       exc_ack,
  output logic                                            exc_req_r,
  output logic [31:0]                                     exc_vector_r,
  output logic [nested_irq_pkg::RANK_W-1:0]               exc_rank_r,
  output logic                                            exc_late_r,
  output logic [nested_irq_pkg::NUM_CHAN-1:0]             chan_pending_r,
  output logic [nested_irq_pkg::CALIB_W-1:0]              system_tick_calib_r
);
  import nested_irq_pkg::*;

  // ==========================================================================
  // Helpers
  function automatic logic [RANK_W-1:0] settable_rank(input logic [PRIO_W-1:0] p);
    return RANK_SET_BASE + RANK_W'(p);
  endfunction

  function automatic logic [31:0] vec_addr(input logic [IDX_W-1:0] i);
    case (i)
      IDX_W'(SRC_NMI):  return VEC_NMI;
      IDX_W'(SRC_HARD): return VEC_HARD;
      IDX_W'(SRC_SVC):  return VEC_SVC;
      IDX_W'(SRC_PSV):  return VEC_PSV;
      IDX_W'(SRC_TICK): return VEC_TICK;
      default:          return VEC_CHAN_BASE + (32'(i - IDX_W'(SRC_CHAN0)) << VEC_SHIFT);
    endcase
  endfunction

  // ==========================================================================
  // Channel lines
  logic [NUM_CHAN-1:0] chan_line;

  always_comb
  begin
    chan_line = periph_irq & ~MERGED_MASK & ~RESERVED_MASK;
    chan_line[CH_RTC] = ext_event_lines[EXT_RTC_ALARM] | ext_event_lines[EXT_RTC_TAMP]
                        | ext_event_lines[EXT_RTC_WAKE];
    chan_line[CH_EXT_LOW] = |ext_event_lines[EXT_LOW_HI:EXT_LOW_LO];
    chan_line[CH_EXT_MID] = |ext_event_lines[EXT_MID_HI:EXT_MID_LO];
    chan_line[CH_EXT_UP]  = |ext_event_lines[EXT_UP_HI:EXT_UP_LO];
    chan_line[CH_XFER_A] = xfer_ch_irq[0] | xfer_ch_irq[1];
    chan_line[CH_XFER_B] = xfer_ch_irq[2] | xfer_ch_irq[3];
    chan_line[CH_ADV_MISC] = |adv_timer_misc_src;
    chan_line[CH_ADV_CC]   = adv_timer_capcmp_irq;
    chan_line[CH_SER_UP] = (|serial_ports_upper_src) | ext_event_lines[EXT_SER_WAKE];
    chan_line[CH_USB] = usb_irq | ext_event_lines[EXT_USB_WAKE];
  end

  // ==========================================================================
  // Pending flags, set on rising edges; a set beats a same-cycle clear
  logic [NUM_SRC-1:0]  src_line;
  logic [NUM_SRC-1:0]  src_prev_r;
  logic [NUM_SRC-1:0]  pend_r;
  logic [NUM_SRC-1:0]  pend_nxt;
  logic [NUM_SRC-1:0]  src_clr;
  logic [IDX_W-1:0]    cur_idx_r;
  entry_state_t        state_r;

  // clock failure feeds the non-maskable source
  // enabled channels join the system exceptions
  assign src_line = {chan_line & chan_enable, system_tick_req, pendable_service_req,
                     supervisor_call_req, hard_fault_req, clock_failure_detector};

  always_comb
  begin
    src_clr = '0;
    if (state_r == ST_ENTRY && exc_ack)
      src_clr[cur_idx_r] = 1'b1;
    pend_nxt = (pend_r & ~src_clr) | (src_line & ~src_prev_r);
  end

  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      src_prev_r <= '0;
      pend_r     <= '0;
    end
    else
    begin
      src_prev_r <= src_line;
      pend_r     <= pend_nxt;
    end
  end

  // ==========================================================================
  // Ranks and arbitration
  logic [NUM_SRC*RANK_W-1:0] rank_vec;
  logic                      sel_valid;
  logic [IDX_W-1:0]          sel_idx;
  logic [RANK_W-1:0]         sel_rank;

  always_comb
  begin
    // fixed ranks below every settable one, so more urgent
    rank_vec = '0;
    rank_vec[SRC_NMI*RANK_W +: RANK_W]  = RANK_NMI;
    rank_vec[SRC_HARD*RANK_W +: RANK_W] = RANK_HARD;
    rank_vec[SRC_SVC*RANK_W +: RANK_W]  = settable_rank(supervisor_call_prio);
    rank_vec[SRC_PSV*RANK_W +: RANK_W]  = settable_rank(pendable_service_prio);
    rank_vec[SRC_TICK*RANK_W +: RANK_W] = settable_rank(system_tick_prio);
    for (int c = 0; c < NUM_CHAN; c++)
      rank_vec[(SRC_CHAN0+c)*RANK_W +: RANK_W] = settable_rank(chan_prio[c*PRIO_W +: PRIO_W]);
  end

  prio_select #(
    .N  (NUM_SRC),
    .IW (IDX_W),
    .RW (RANK_W)
  ) u_sel (
    .pend     (pend_r),
    .rank     (rank_vec),
    .valid    (sel_valid),
    .idx      (sel_idx),
    .rank_out (sel_rank)
  );

  // ==========================================================================
  // Entry sequence towards the core
  entry_state_t      state_nxt;
  logic [IDX_W-1:0]  cur_idx_nxt;
  logic [RANK_W-1:0] cur_rank_nxt;
  logic              late_nxt;

  always_comb
  begin
    state_nxt    = state_r;
    cur_idx_nxt  = cur_idx_r;
    cur_rank_nxt = exc_rank_r;
    late_nxt     = 1'b0;
    case (state_r)
      ST_IDLE:
      begin
        if (sel_valid)
        begin
          state_nxt    = ST_ENTRY;
          cur_idx_nxt  = sel_idx;
          cur_rank_nxt = sel_rank;
        end
      end
      ST_ENTRY:
      begin
        // request stands until the core takes it
        if (exc_ack)
          state_nxt = ST_IDLE;
        // a strictly more urgent arrival swaps the vector before acceptance
        else if (sel_valid && sel_rank < exc_rank_r)
        begin
          cur_idx_nxt  = sel_idx;
          cur_rank_nxt = sel_rank;
          late_nxt     = 1'b1;
        end
      end
      default:
        state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      state_r         <= ST_IDLE;
      cur_idx_r       <= '0;
      exc_req_r       <= 1'b0;
      exc_vector_r    <= '0;
      exc_rank_r      <= RANK_LOWEST;
      exc_late_r      <= 1'b0;
      chan_pending_r  <= '0;
      system_tick_calib_r <= TICK_CALIB;
    end
    else
    begin
      state_r         <= state_nxt;
      cur_idx_r       <= cur_idx_nxt;
      exc_req_r       <= (state_nxt == ST_ENTRY);
      exc_vector_r    <= vec_addr(cur_idx_nxt);
      exc_rank_r      <= cur_rank_nxt;
      exc_late_r      <= late_nxt;
      chan_pending_r  <= pend_nxt[NUM_SRC-1:SRC_CHAN0];
      system_tick_calib_r <= TICK_CALIB;
    end
  end

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  nmi_vector_a: assert property (pend_r[SRC_NMI] && state_r == ST_IDLE |=> exc_vector_r == 32'h0000_0008)
    else $error("non-maskable entry not at its vector");
  clk_fail_a: assert property ($rose(clock_failure_detector) ##1 state_r == ST_IDLE |=> exc_req_r && exc_rank_r == 3'h0)
    else $error("clock failure did not raise non-maskable entry");
  late_swap_a: assert property (exc_late_r |-> exc_req_r && exc_rank_r < $past(exc_rank_r))
    else $error("late arrival not more urgent");
  req_hold_a: assert property (exc_req_r && !exc_ack |=> exc_req_r)
    else $error("request dropped before acceptance");
  calib_value_a: assert property (system_tick_calib_r == 24'h001770)
    else $error("tick calibration not 6000");
  rank_range_a: assert property (exc_req_r && cur_idx_r >= IDX_W'(SRC_SVC) |-> exc_rank_r >= 3'h2 && exc_rank_r <= 3'h5)
    else $error("settable rank out of four levels");
  reserved_idle_a: assert property (!pend_r[SRC_CHAN0+1] && !pend_r[SRC_CHAN0+30])
    else $error("reserved position pending");
  rtc_merge_a: assert property (chan_enable[CH_RTC] && ext_event_lines[EXT_RTC_WAKE]
    && !src_prev_r[SRC_CHAN0+CH_RTC] |=> pend_r[SRC_CHAN0+CH_RTC])
    else $error("clock event line not pending on channel 2");
  svc_vector_a: assert property (exc_req_r && cur_idx_r == IDX_W'(SRC_SVC) |-> exc_vector_r == 32'h0000_002C)
    else $error("supervisor call vector wrong");
  psv_vector_a: assert property (exc_req_r && cur_idx_r == IDX_W'(SRC_PSV) |-> exc_vector_r == 32'h0000_0038)
    else $error("pendable service vector wrong");
  usb_vector_a: assert property (exc_req_r && cur_idx_r == IDX_W'(SRC_CHAN0+CH_USB) |-> exc_vector_r == 32'h0000_00BC)
    else $error("channel 31 vector wrong");

  late_seen_c: cover property (exc_late_r ##[1:8] exc_ack);
  nmi_entry_c: cover property (exc_req_r && exc_vector_r == VEC_NMI ##1 exc_ack);
  usb_taken_c: cover property (exc_req_r && exc_vector_r == 32'h0000_00BC && exc_ack);

endmodule

//--- verification/core_ack_model.sv
// Core side model: takes each presented exception after a set number of cycles
`timescale 1ns/1ps
module core_ack_model (
  input  wire logic       clk_sys,
  input  wire logic       nrst,
  input  wire logic       exc_req_r,
  input  wire logic [7:0] ack_delay,
  output logic            exc_ack
);
  // ==========================================================================
  // Acknowledge handshake
  logic [7:0] wait_r;
  logic       taken_r;
  // one ack per presentation
  // Taken flag stops a second ack while the request is still falling
  always @(posedge clk_sys)
  begin
    if (!nrst || !exc_req_r)
    begin
      wait_r  <= 8'h00;
      taken_r <= 1'b0;
      exc_ack <= 1'b0;
    end
    else
    begin
      wait_r  <= wait_r + 8'h01;
      exc_ack <= !taken_r && (wait_r >= ack_delay);
      taken_r <= taken_r || (wait_r >= ack_delay);
    end
  end
endmodule

//--- verification/nested_irq_vector_map_tb.sv
// Self-checking bench for the nested interrupt controller
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin err_total++; $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module nested_irq_vector_map_tb;
  import nested_irq_pkg::*;
  // ==========================================================================
  // Signals
  logic        clk_sys = 0, nrst = 0, exc_ack, exc_req_r, exc_late_r;
  logic [31:0] periph_irq = 0, ext_event_lines = 0, chan_enable = '1, exc_vector_r, chan_pending_r;
  logic [3:0]  xfer_ch_irq = 0, adv_timer_misc_src = 0, serial_ports_upper_src = 0;
  logic        adv_timer_capcmp_irq = 0, usb_irq = 0, clock_failure_detector = 0;
  logic        hard_fault_req = 0, supervisor_call_req = 0, pendable_service_req = 0, system_tick_req = 0;
  logic [63:0] chan_prio = 0;
  logic [1:0]  supervisor_call_prio = 0, pendable_service_prio = 0, system_tick_prio = 0;
  logic [2:0]  exc_rank_r;
  logic [23:0] system_tick_calib_r;
  logic [7:0]  ack_delay = 8'h05;
  int          err_total = 0, cmp_count = 0;
  // Merged sources: kind, bit, channel
  int mk[23] = '{1,1,1,1,1,1,1,1,1,2,2,2,2,3,3,3,3,5,4,4,1,5,1};
  int mb[23] = '{17,19,20,0,1,2,3,4,15,0,1,2,3,0,1,2,3,0,0,3,28,1,18};
  int mc[23] = '{2,2,2,5,5,6,6,7,7,10,10,11,11,13,13,13,13,14,29,29,29,31,31};

  always #50 clk_sys = ~clk_sys;

  nested_irq_ctrl uut (.clk_sys, .nrst, .periph_irq, .ext_event_lines, .xfer_ch_irq, .adv_timer_misc_src,
    .adv_timer_capcmp_irq, .serial_ports_upper_src, .usb_irq, .clock_failure_detector, .hard_fault_req,
    .supervisor_call_req, .pendable_service_req, .system_tick_req, .chan_enable, .chan_prio,
    .supervisor_call_prio, .pendable_service_prio, .system_tick_prio, .exc_ack, .exc_req_r, .exc_vector_r,
    .exc_rank_r, .exc_late_r, .chan_pending_r, .system_tick_calib_r);
  core_ack_model core_side (.clk_sys, .nrst, .exc_req_r, .ack_delay, .exc_ack);

  // ==========================================================================
  // Shared tasks
  task automatic src(input int k, input int b, input logic v);
    case (k)
      0: periph_irq[b] = v;
      1: ext_event_lines[b] = v;
      2: xfer_ch_irq[b] = v;
      3: adv_timer_misc_src[b] = v;
      4: serial_ports_upper_src[b] = v;
      default:
      begin
        case (b)
          0: adv_timer_capcmp_irq = v;
          1: usb_irq = v;
          2: clock_failure_detector = v;
          3: hard_fault_req = v;
          4: supervisor_call_req = v;
          5: pendable_service_req = v;
          default: system_tick_req = v;
        endcase
      end
    endcase
  endtask

  task automatic seen(input logic [31:0] v, input logic [2:0] r);
    for (int i = 0; i < 30 && exc_req_r !== 1'b1; i++)
    begin
      @(posedge clk_sys);
      #1;
    end
    `CHK(exc_req_r, 1'b1)
    `CHK(exc_vector_r, v)
    `CHK(exc_rank_r, r)
  endtask

  task automatic gone();
    for (int i = 0; i < 60 && exc_req_r !== 1'b0; i++)
    begin
      @(posedge clk_sys);
      #1;
    end
    `CHK(exc_req_r, 1'b0)
  endtask

  task automatic fire(input int k, input int b, input logic [31:0] v, input logic [2:0] r);
    @(negedge clk_sys);
    src(k, b, 1'b1);
    @(negedge clk_sys);
    src(k, b, 1'b0);
    // only the channel of this vector is pending
    `CHK(chan_pending_r, (v >= 32'h0000_0040) ? (32'h0000_0001 << ((v - 32'h0000_0040) >> 2)) : 32'h0000_0000)
    seen(v, r);
    gone();
    `CHK(chan_pending_r, 32'h0000_0000)
  endtask

  task automatic done(input string name);
    $display("test %s finished, mismatches so far %0d", name, err_total);
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_reset();
    `CHK(system_tick_calib_r, 24'h001770)
    `CHK(exc_rank_r, 3'h5)
    `CHK(exc_req_r, 1'b0)
    done("reset");
  endtask

  task automatic t_channels();
    for (int n = 0; n < 32; n++)
      if (!(n inside {1, 2, 5, 6, 7, 8, 10, 11, 13, 14, 15, 29, 30, 31}))
        fire(0, n, 32'h0000_0040 + 32'(4 * n), 3'h2);
    for (int i = 0; i < 23; i++)
      fire(mk[i], mb[i], 32'h0000_0040 + 32'(4 * mc[i]), 3'h2);
    done("channels");
  endtask

  task automatic t_system();
    fire(5, 2, 32'h0000_0008, 3'h0);
    fire(5, 3, 32'h0000_000C, 3'h1);
    for (int l = 0; l < 4; l++)
    begin
      @(negedge clk_sys);
      supervisor_call_prio = 2'(l);
      pendable_service_prio = 2'(3 - l);
      system_tick_prio = 2'(l);
      chan_prio[1:0] = 2'(3 - l);
      fire(5, 4, 32'h0000_002C, 3'(2 + l));
      fire(5, 5, 32'h0000_0038, 3'(5 - l));
      fire(5, 6, 32'h0000_003C, 3'(2 + l));
      fire(0, 0, 32'h0000_0040, 3'(5 - l));
    end
    done("system");
  endtask

  task automatic t_order();
    ack_delay = 8'h0A;
    @(negedge clk_sys);
    chan_prio[7:6] = 2'h3;
    chan_prio[19:18] = 2'h1;
    periph_irq[3] = 1'b1;
    periph_irq[9] = 1'b1;
    periph_irq[4] = 1'b1;
    periph_irq[12] = 1'b1;
    @(negedge clk_sys);
    periph_irq = 32'h0;
    seen(32'h0000_0050, 3'h2);
    gone();
    seen(32'h0000_0070, 3'h2);
    gone();
    seen(32'h0000_0064, 3'h3);
    gone();
    seen(32'h0000_004C, 3'h5);
    gone();
    @(negedge clk_sys);
    chan_prio = 64'h0;
    done("order");
  endtask

  task automatic t_late();
    ack_delay = 8'h14;
    @(negedge clk_sys);
    system_tick_prio = 2'h2;
    system_tick_req = 1'b1;
    seen(32'h0000_003C, 3'h4);
    @(negedge clk_sys);
    clock_failure_detector = 1'b1;
    for (int i = 0; i < 10 && exc_vector_r === 32'h0000_003C; i++)
    begin
      @(posedge clk_sys);
      #1;
    end
    `CHK(exc_late_r, 1'b1)
    `CHK(exc_vector_r, 32'h0000_0008)
    `CHK(exc_rank_r, 3'h0)
    @(posedge clk_sys);
    #1;
    `CHK(exc_late_r, 1'b0)
    gone();
    seen(32'h0000_003C, 3'h4);
    gone();
    @(negedge clk_sys);
    clock_failure_detector = 1'b0;
    system_tick_req = 1'b0;
    ack_delay = 8'h05;
    done("late");
  endtask

  task automatic t_refuse();
    @(negedge clk_sys);
    chan_enable[20] = 1'b0;
    periph_irq[20] = 1'b1;
    periph_irq[1] = 1'b1;
    periph_irq[16] = 1'b1;
    seen(32'h0000_0080, 3'h2);
    gone();
    repeat (8) @(posedge clk_sys);
    #1;
    `CHK(exc_req_r, 1'b0)
    `CHK(chan_pending_r, 32'h0000_0000)
    @(negedge clk_sys);
    periph_irq = 32'h0;
    chan_enable = '1;
    done("refuse");
  endtask

  task automatic stop_test();
    $display("comparisons %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ==========================================================================
  // Sequence and watchdog
  initial
  begin
    repeat (12) @(negedge clk_sys);
    t_reset();
    nrst = 1'b1;
    repeat (2) @(negedge clk_sys);
    t_channels();
    t_system();
    t_order();
    t_late();
    t_refuse();
    stop_test();
  end

  initial
  begin
    #(100 * 20000);
    err_total++;
    stop_test();
  end
endmodule
